// *** rtl/rsc_top.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - brown-out flag sets on supply crossing either way, software clears it
// - flag with both interrupt enables high raises brown-out request
// - brown-out resets processor only when its reset enable is set
// - pin low at least two machine cycles is a valid reset
// - pin is synchronised; reset applied synchronously, needs running clock
// - reset stays asserted while pin stays low
// - after pin release leave reset within two machine cycles
// - no flag for pin reset; all flags clear can also follow software reset or immediate watchdog reset
// - pin in power-down wakes clock asynchronously, then resets normally
// - watchdog reset holds system reset for two machine cycles
// - writing one to watchdog clear restarts the watchdog count
// - watchdog reset flag set on time-out with delayed enable, survives non power-on
// - delayed enable zero: time-out resets at once, no flag
// - delayed enable one: flag, interrupt, reset after 512 clocks
// - delayed enable is bit 0 of its register, resets to zero
// - chip control bit 7 triggers software reset, clears when done
// - boot select zero before software reset reboots application memory
module rsc_top
(
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [9:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic             reset_pin_n,
  input  wire logic             brownout_level,
  input  wire logic             brownout_irq_enable,
  input  wire logic             global_irq_enable,
  input  wire logic             watchdog_irq_enable,
  input  wire logic             watchdog_timeout,
  input  wire logic             power_down,
  input  wire logic             boot_strap_loader,
  output logic                  system_reset,
  output logic                  brownout_irq,
  output logic                  watchdog_irq,
  output logic                  watchdog_count_restart,
  output rsc_pkg::rsc_wdctl_t   watchdog_config,
  output logic                  boot_from_loader,
  output logic                  clock_wake
);
  import rsc_pkg::*;
  rsc_state_t   st;
  rsc_chip_t    chip;
  rsc_pmc_t     pmc;
  logic         delayed_en;
  logic [CW-1:0] hold_cnt, pin_cnt, key_cnt, grace_cnt;
  logic         sw_cause, next_boot;
  logic         pin_s1, pin_s2, bod_s1, bod_s2, bod_s3;
  logic         key_armed, ta_open, grace_act;
  logic         wr_go, rd_go, pin_valid, bod_event;
  logic         wdt_rst, bod_rst, fixed_req, prot_ok, clr_go;
  logic [7:0]   wd;
  function automatic logic hit(input logic [7:0] idx);
    hit = (avs_address == {idx, IDX_LANE});
  endfunction : hit
  // one wait state: request seen, then accepted on the next edge
  always_ff @(posedge clock) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end
  assign wr_go = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign rd_go = avs_read & avs_waitrequest;
  assign wd    = avs_writedata[7:0];
  // read data loaded as waitrequest falls; unmapped reads give zero
  always_ff @(posedge clock) begin
    if (!resetn) begin
      avs_readdata <= '0;
    end else if (rd_go) begin
      avs_readdata <= '0;
      if (hit(IDX_CHIP))
        avs_readdata[7:0] <= {chip[7:2], boot_from_loader, chip[0]};
      else if (hit(IDX_WDMODE))
        avs_readdata[0] <= delayed_en;
      else if (hit(IDX_WDCTL))
        avs_readdata[7:0] <= watchdog_config & ~8'h40;
      else if (hit(IDX_PMC))
        avs_readdata[7:0] <= pmc;
    end
  end
  // two-stage synchronisers; pin uses stage two, brown-out edge uses stages two and three
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      bod_s1 <= 1'b0;
      bod_s2 <= 1'b0;
      bod_s3 <= 1'b0;
    end else begin
      pin_s1 <= reset_pin_n;
      pin_s2 <= pin_s1;
      bod_s1 <= brownout_level;
      bod_s2 <= bod_s1;
      bod_s3 <= bod_s2;
    end
  end
  assign bod_event = (bod_s2 ^ bod_s3) & pmc.bod_enable;
  // count low samples so short glitches never reset the chip
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pin_cnt <= '0;
    end else if (pin_s2) begin
      pin_cnt <= '0;
    end else if (pin_cnt != PIN_MIN_CLK) begin
      pin_cnt <= pin_cnt + CNT_ONE;
    end
  end
  assign pin_valid = (pin_cnt == PIN_MIN_CLK);
  // raw pin path: the clock is stopped, so no flop can carry this
  assign clock_wake = power_down & ~reset_pin_n;
  // timed access: AA then 55 inside the window opens one write
  assign prot_ok = ta_open;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      key_armed <= 1'b0;
      ta_open   <= 1'b0;
      key_cnt   <= '0;
    end else begin
      if (key_armed)
        key_cnt <= key_cnt + CNT_ONE;
      if (key_armed && key_cnt == KEY_LAST)
        key_armed <= 1'b0;
      if (wr_go && hit(IDX_TAKEY)) begin
        key_armed <= (wd == KEY_FIRST);
        key_cnt   <= '0;
        ta_open   <= key_armed && (wd == KEY_SECOND);
      end else if (wr_go && (hit(IDX_CHIP) || hit(IDX_WDMODE) ||
                             hit(IDX_WDCTL) || hit(IDX_PMC))) begin
        ta_open <= 1'b0;
      end
    end
  end
  assign clr_go = wr_go && hit(IDX_WDCTL) && prot_ok && wd[6];
  // delayed-reset grace window after a time-out
  always_ff @(posedge clock) begin
    if (!resetn || system_reset) begin
      grace_act <= 1'b0;
      grace_cnt <= '0;
    end else if (clr_go) begin
      grace_act <= 1'b0;
    end else if (watchdog_timeout && delayed_en && !grace_act) begin
      grace_act <= 1'b1;
      grace_cnt <= '0;
    end else if (grace_act) begin
      grace_cnt <= grace_cnt + CNT_ONE;
    end
  end
  assign wdt_rst = (watchdog_timeout & ~delayed_en) |
                   (grace_act & (grace_cnt == GRACE_LAST));
  assign bod_rst = bod_event & pmc.bod_reset_enable;
  assign fixed_req = wdt_rst | bod_rst | chip.software_reset_request;
  // merge all sources into one reset; no pin flag exists
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st           <= ST_HOLD;
      hold_cnt     <= '0;
      system_reset <= 1'b1;
      sw_cause     <= 1'b0;
    end else begin
      unique case (st)
        ST_RUN: begin
          if (pin_valid) begin
            st           <= ST_PIN;
            system_reset <= 1'b1;
          end else if (fixed_req) begin
            st           <= ST_HOLD;
            hold_cnt     <= '0;
            system_reset <= 1'b1;
            sw_cause     <= chip.software_reset_request;
          end
        end
        ST_PIN: begin
          if (pin_s2) begin
            st           <= ST_RUN;
            system_reset <= 1'b0;
            sw_cause     <= 1'b0;
          end
        end
        ST_HOLD: begin
          if (pin_valid) begin
            st       <= ST_PIN;
            sw_cause <= 1'b0;
          end else if (hold_cnt == HOLD_LAST) begin
            st           <= ST_RUN;
            system_reset <= 1'b0;
            sw_cause     <= 1'b0;
          end else begin
            hold_cnt <= hold_cnt + CNT_ONE;
          end
        end
      endcase
    end
  end
  // boot choice: strap at every reset but software reset
  always_ff @(posedge clock) begin
    if (!resetn) begin
      next_boot        <= 1'b0;
      boot_from_loader <= 1'b0;
    end else begin
      if (system_reset && !sw_cause)
        next_boot <= boot_strap_loader;
      else if (wr_go && hit(IDX_CHIP) && prot_ok)
        next_boot <= wd[1];
      if (system_reset)
        boot_from_loader <= next_boot;
    end
  end
  // chip control; software reset bit clears once its reset ends
  always_ff @(posedge clock) begin
    if (!resetn) begin
      chip <= '0;
    end else if (st == ST_HOLD && sw_cause && hold_cnt == HOLD_LAST) begin
      chip <= '0;
    end else if (system_reset && !sw_cause) begin
      chip <= '0;
    end else if (wr_go && hit(IDX_CHIP) && prot_ok) begin
      chip <= wd & 8'hE1;
    end
  end

  // delayed-reset enable, cleared by every system reset
  always_ff @(posedge clock) begin
    if (!resetn || system_reset) begin
      delayed_en <= 1'b0;
    end else if (wr_go && hit(IDX_WDMODE) && prot_ok) begin
      delayed_en <= wd[0];
    end
  end

  // watchdog control; flags are hardware-set, set beats clear
  always_ff @(posedge clock) begin
    if (!resetn) begin
      watchdog_config <= '0;
    end else begin
      if (wr_go && hit(IDX_WDCTL) && prot_ok)
        watchdog_config <= wd & ~8'h40;
      if (watchdog_timeout && delayed_en) begin
        watchdog_config.reset_flag   <= 1'b1;
        watchdog_config.timeout_flag <= 1'b1;
      end
    end
  end

  // restart pulse for the external watchdog counter
  always_ff @(posedge clock) begin
    if (!resetn) begin
      watchdog_count_restart <= 1'b0;
    end else begin
      watchdog_count_restart <= clr_go;
    end
  end

  // power monitor; reserved low bits never store, bit 5 too
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pmc <= '0;
    end else begin
      if (wr_go && hit(IDX_PMC) && prot_ok)
        pmc <= wd & 8'hD8;
      if (bod_event)
        pmc.brownout_flag <= 1'b1;
    end
  end

  // interrupt requests, registered
  always_ff @(posedge clock) begin
    if (!resetn) begin
      brownout_irq <= 1'b0;
      watchdog_irq <= 1'b0;
    end else begin
      brownout_irq <= pmc.brownout_flag & brownout_irq_enable &
                      global_irq_enable;
      watchdog_irq <= watchdog_config.timeout_flag & watchdog_irq_enable;
    end
  end

  AST_BOF_SET: assert property (@(posedge clock) disable iff (!resetn)
    bod_event |=> pmc.brownout_flag)
    else $error("brown-out flag not set");
  AST_BOD_IRQ: assert property (@(posedge clock) disable iff (!resetn)
    pmc.brownout_flag && brownout_irq_enable && global_irq_enable
    |=> brownout_irq)
    else $error("brown-out request missing");
  AST_BOD_NORST: assert property (@(posedge clock) disable iff (!resetn)
    st == ST_RUN && bod_event && !pmc.bod_reset_enable && !wdt_rst &&
    !chip.software_reset_request && !pin_valid |=> !system_reset)
    else $error("brown-out reset while disabled");
  AST_PIN_VALID: assert property (@(posedge clock) disable iff (!resetn)
    !pin_s2 [*8] ##1 !pin_s2 |=> system_reset)
    else $error("long pin low did not reset");
  AST_PIN_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    st == ST_PIN && !pin_s2 |=> system_reset && st == ST_PIN)
    else $error("reset dropped while pin low");
  AST_PIN_EXIT: assert property (@(posedge clock) disable iff (!resetn)
    st == ST_PIN && pin_s2 |=> !system_reset)
    else $error("late exit after pin release");
  AST_WDT_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    st == ST_RUN && wdt_rst && !pin_valid && pin_s2
    |=> system_reset [*8] ##1 (!system_reset || !pin_s2 || pin_valid))
    else $error("watchdog hold length wrong");
  AST_WDT_NOFLAG: assert property (@(posedge clock) disable iff (!resetn)
    watchdog_timeout && !delayed_en && !watchdog_config.reset_flag &&
    !wr_go |=> !watchdog_config.reset_flag)
    else $error("flag set with delayed reset off");
  AST_GRACE: assert property (@(posedge clock) disable iff (!resetn)
    st == ST_RUN && watchdog_timeout && delayed_en && !grace_act &&
    !fixed_req && !pin_valid
    |=> watchdog_config.reset_flag && !system_reset)
    else $error("grace window not entered");
  AST_CLR: assert property (@(posedge clock) disable iff (!resetn)
    clr_go |=> watchdog_count_restart && !grace_act)
    else $error("watchdog clear ignored");
  AST_SOFTWARE_RESET_REQUEST_CLR: assert property (@(posedge clock) disable iff (!resetn)
    $fell(system_reset) && $past(sw_cause) |-> !chip.software_reset_request)
    else $error("software reset bit stuck");

  COV_PIN: cover property (@(posedge clock) disable iff (!resetn)
    st == ST_PIN ##1 st == ST_RUN);
  COV_GRACE: cover property (@(posedge clock) disable iff (!resetn)
    grace_act && grace_cnt == GRACE_LAST);
  COV_SOFTWARE_RESET_REQUEST: cover property (@(posedge clock) disable iff (!resetn)
    st == ST_RUN && chip.software_reset_request);
endmodule : rsc_top

// *** rtl/rsc_pkg.sv ***
package rsc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CHIP   = 8'h9F;
  localparam logic [7:0] IDX_WDMODE = 8'hAB;
  localparam logic [7:0] IDX_WDCTL  = 8'hD8;
  localparam logic [7:0] IDX_PMC    = 8'hA3;
  localparam logic [7:0] IDX_TAKEY  = 8'hC7;
  localparam logic [1:0] IDX_LANE   = 2'h0;
  // unlock key bytes
  localparam logic [7:0] KEY_FIRST  = 8'hAA;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  // timing in machine cycles and clocks
  localparam int MC_CLOCKS     = 4;
  localparam int PIN_MIN_MC    = 2;
  localparam int HOLD_MC       = 2;
  localparam int KEY_WINDOW_MC = 3;
  localparam int GRACE_CLOCKS  = 512;
  localparam int CW            = 10;
  localparam logic [CW-1:0] PIN_MIN_CLK = CW'(PIN_MIN_MC * MC_CLOCKS);
  localparam logic [CW-1:0] HOLD_LAST   = CW'(HOLD_MC * MC_CLOCKS - 1);
  localparam logic [CW-1:0] KEY_LAST    = CW'(KEY_WINDOW_MC * MC_CLOCKS - 1);
  localparam logic [CW-1:0] GRACE_LAST  = CW'(GRACE_CLOCKS - 1);
  localparam logic [CW-1:0] CNT_ONE     = CW'(1);

  // watchdog control layout, msb first
  typedef struct packed {
    logic       enable;
    logic       clear;
    logic       timeout_flag;
    logic       run_in_powerdown;
    logic       reset_flag;
    logic [2:0] prescale;
  } rsc_wdctl_t;

  // power monitor control layout
  typedef struct packed {
    logic       bod_enable;
    logic       bod_level_sel;
    logic       rsv5;
    logic       bod_reset_enable;
    logic       brownout_flag;
    logic [2:0] rsv;
  } rsc_pmc_t;

  // chip control layout
  typedef struct packed {
    logic       software_reset_request;
    logic       program_fail_flag;
    logic       loader_update_enable;
    logic [2:0] rsv;
    logic       boot_select;
    logic       self_program_enable;
  } rsc_chip_t;

  typedef enum logic [1:0] {ST_RUN, ST_PIN, ST_HOLD} rsc_state_t;
endpackage : rsc_pkg

// *** testbench/rsc_far_side.sv ***
`timescale 1ns/10ps
// external reset circuit and watchdog counter on the far side of the block
module rsc_far_side (
  input  wire logic       clock,
  input  wire logic       pin_go,
  input  wire logic [7:0] pin_len,
  input  wire logic       wd_go,
  input  wire logic       watchdog_count_restart,
  output logic            reset_pin_n,
  output logic            watchdog_timeout,
  output logic [7:0]      restarts
);
  logic [7:0] left;
  initial begin
    left = 8'h00;
    restarts = 8'h00;
    watchdog_timeout = 1'b0;
  end
  // pin held low for the commanded count, then back to the pull-up level
  always @(posedge clock) begin
    if (pin_go) begin
      left <= pin_len;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign reset_pin_n = (left == 8'h00);
  // time-out is a single-cycle pulse; restarts are counted for the bench
  always @(posedge clock) begin
    watchdog_timeout <= wd_go;
    if (watchdog_count_restart === 1'b1) begin
      restarts <= restarts + 8'h01;
    end
  end
endmodule : rsc_far_side

// *** testbench/rsc_top_tb.sv ***
`timescale 1ns/10ps
module rsc_top_tb;
  import rsc_pkg::*;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        bo_lvl = 1'b0;
  logic        bo_ie = 1'b1;
  logic        g_ie = 1'b1;
  logic        wd_ie = 1'b0;
  logic        pdown = 1'b0;
  logic        strap = 1'b1;
  logic        pin_go = 1'b0;
  logic [7:0]  pin_len = 8'h00;
  logic        wd_go = 1'b0;
  logic        reset_pin_n, watchdog_timeout, system_reset, brownout_irq;
  logic        watchdog_irq, wd_restart, boot_from_loader, clock_wake;
  logic [7:0]  restarts, rd, r0;
  rsc_wdctl_t  wd_cfg;
  int          errors = 0;
  int          compares = 0;
  int          seed = 93218;
  int          n;
  logic        seen;

  // 25 ns period
  always #12.5 clock = ~clock;

  rsc_top u_rsc_top (.clock(clock), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .reset_pin_n(reset_pin_n), .brownout_level(bo_lvl),
    .brownout_irq_enable(bo_ie), .global_irq_enable(g_ie),
    .watchdog_irq_enable(wd_ie), .watchdog_timeout(watchdog_timeout),
    .power_down(pdown), .boot_strap_loader(strap),
    .system_reset(system_reset), .brownout_irq(brownout_irq),
    .watchdog_irq(watchdog_irq), .watchdog_count_restart(wd_restart),
    .watchdog_config(wd_cfg), .boot_from_loader(boot_from_loader),
    .clock_wake(clock_wake));
  rsc_far_side u_rsc_far_side (.clock(clock), .pin_go(pin_go),
    .pin_len(pin_len), .wd_go(wd_go), .watchdog_count_restart(wd_restart),
    .reset_pin_n(reset_pin_n), .watchdog_timeout(watchdog_timeout),
    .restarts(restarts));

  function automatic int hold_clocks();
    return HOLD_MC * MC_CLOCKS;
  endfunction : hold_clocks

  task automatic end_of_test;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] q);
    int k;
    k = 0;
    @(posedge clock);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h000000, wd};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clock);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (k >= 20) begin
      errors++;
      end_of_test();
    end
  endtask : bus

  // protected write: fresh unlock for every write
  task automatic pwr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] q;
    bus(1'b1, IDX_TAKEY, KEY_FIRST, q);
    bus(1'b1, IDX_TAKEY, KEY_SECOND, q);
    bus(1'b1, idx, wd, q);
  endtask : pwr

  // bounded wait for a reset level; k returns the cycles spent
  task automatic wait_sr(input logic lvl, output int k);
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (system_reset !== lvl && k < 2000);
    if (k >= 2000) begin
      errors++;
      end_of_test();
    end
  endtask : wait_sr

  task automatic pulse_pin(input logic [7:0] len);
    @(posedge clock);
    pin_len <= len;
    pin_go  <= 1'b1;
    @(posedge clock);
    pin_go  <= 1'b0;
  endtask : pulse_pin

  task automatic fire_wd;
    @(posedge clock);
    wd_go <= 1'b1;
    @(posedge clock);
    wd_go <= 1'b0;
  endtask : fire_wd

  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    wait_sr(1'b0, n);
    chk(n, hold_clocks() + 1);
    bus(1'b0, IDX_WDMODE, 8'h00, rd);
    chk(rd, 8'h00);
    bus(1'b0, 8'h10, 8'h00, rd);
    chk(rd, 8'h00);
    chk(boot_from_loader, 1'b1);
    $display("done: reset values");
    // short pin low is ignored, long one holds reset
    pulse_pin(8'h05);
    seen = 1'b0;
    repeat (20) @(posedge clock) seen |= system_reset;
    chk(seen, 1'b0);
    pulse_pin(8'h20);
    repeat (28) @(posedge clock);
    chk({reset_pin_n, system_reset}, 2'b01);
    n = 0;
    while (reset_pin_n !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n >= 50) begin
      errors++;
      end_of_test();
    end
    wait_sr(1'b0, n);
    chk(n <= 2 * MC_CLOCKS, 1'b1);
    bus(1'b0, IDX_WDCTL, 8'h00, rd);
    chk(rd[3], 1'b0);
    $display("done: pin reset");
    // wake request while powered down
    pdown <= 1'b1;
    pulse_pin(8'h03);
    @(posedge clock);
    chk(clock_wake, 1'b1);
    pdown <= 1'b0;
    repeat (4) @(posedge clock);
    // immediate watchdog reset
    fire_wd();
    wait_sr(1'b1, n);
    wait_sr(1'b0, n);
    chk(n, hold_clocks());
    bus(1'b0, IDX_WDCTL, 8'h00, rd);
    chk(rd[3], 1'b0);
    $display("done: watchdog immediate");
    // delayed watchdog reset after the grace window
    pwr(IDX_WDMODE, 8'h01);
    bus(1'b0, IDX_WDMODE, 8'h00, rd);
    chk(rd, 8'h01);
    wd_ie <= 1'b1;
    fire_wd();
    repeat (3) @(posedge clock);
    chk(watchdog_irq, 1'b1);
    wait_sr(1'b1, n);
    chk(n >= GRACE_CLOCKS - 4 && n <= GRACE_CLOCKS + 2, 1'b1);
    wait_sr(1'b0, n);
    bus(1'b0, IDX_WDCTL, 8'h00, rd);
    chk({rd[5], rd[3]}, 2'b11);
    $display("done: watchdog delayed");
    // clearing inside the grace window cancels the reset
    pwr(IDX_WDMODE, 8'h01);
    r0 = restarts;
    fire_wd();
    pwr(IDX_WDCTL, 8'h40);
    repeat (3) @(posedge clock);
    chk(restarts, r0 + 8'h01);
    seen = 1'b0;
    repeat (600) @(posedge clock) seen |= system_reset;
    chk(seen, 1'b0);
    wd_ie <= 1'b0;
    // random prescale settings read back on the config port
    for (int i = 0; i < 3; i++) begin
      r0 = 8'($random(seed)) & 8'h07;
      pwr(IDX_WDCTL, r0);
      @(posedge clock);
      chk(wd_cfg, r0);
    end
    $display("done: watchdog clear");
    // brownout records and interrupts, no reset while disabled
    pwr(IDX_PMC, 8'h80);
    bo_lvl <= 1'b1;
    repeat (8) @(posedge clock);
    bus(1'b0, IDX_PMC, 8'h00, rd);
    chk({rd[3], brownout_irq, system_reset}, 3'b110);
    g_ie <= 1'b0;
    repeat (3) @(posedge clock);
    chk(brownout_irq, 1'b0);
    // brown-out reset when enabled, on a falling crossing
    pwr(IDX_PMC, 8'h90);
    bo_lvl <= 1'b0;
    wait_sr(1'b1, n);
    chk(n <= MC_CLOCKS, 1'b1);
    wait_sr(1'b0, n);
    bus(1'b0, IDX_PMC, 8'h00, rd);
    chk(rd, 8'h98);
    $display("done: brownout");
    // software reset into application memory
    pwr(IDX_CHIP, 8'h00);
    pwr(IDX_CHIP, 8'h80);
    wait_sr(1'b1, n);
    wait_sr(1'b0, n);
    chk(boot_from_loader, 1'b0);
    bus(1'b0, IDX_CHIP, 8'h00, rd);
    chk(rd[7], 1'b0);
    $display("done: software reset");
    end_of_test();
  end
endmodule : rsc_top_tb
